// ===== vdpg_regs.svh
// Purpose: Register map and constants of the visibility dimming generator
// Assumes: AHB-Lite, 32-bit words, byte addresses
// Notes: Definitions only
`ifndef VDPG_REGS_SVH
`define VDPG_REGS_SVH
`define VDPG_OFS_CTRL 8'h00
`define VDPG_OFS_DIM 8'h04
`define VDPG_OFS_FLEN 8'h08
`define VDPG_OFS_COMP 8'h0c
`define VDPG_OFS_STAT 8'h10
`define VDPG_OFS_DATA 8'h14
`define VDPG_OFS_CSK 8'h18
`define VDPG_CTRL_EN 0
`define VDPG_CTRL_DATA 1
`define VDPG_CTRL_OOB 2
`define VDPG_CTRL_CSK 3
`define VDPG_DIM_MAX 10'h3e8
`define VDPG_STEP 10'h064
`define VDPG_DATA_LO 10'h064
`define VDPG_DATA_HI 10'h384
`define VDPG_PAT_W 4'ha
`define VDPG_FLEN_RST 16'h0064
`define VDPG_HTRANS_NSEQ 2'h2
`endif

// ===== vdpg_pkg.sv
// Purpose: Types shared by the visibility dimming generator
// Assumes: Nothing
// Notes: Gray codes along the usual path
package vdpg_pkg;
    typedef enum logic [2:0] {
        VDPG_IDLE = 3'h0,
        VDPG_LOWER = 3'h1,
        VDPG_UPPER = 3'h3,
        VDPG_COMP = 3'h2,
        VDPG_DATA = 3'h6
    } vdpg_state_e;
    typedef struct packed {
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } vdpg_csk_s;
    typedef struct packed {
        logic en;
        logic data_mode;
        logic oob;
        logic csk;
    } vdpg_ctrl_s;
endpackage

// ===== vdpg_top.sv
// Purpose: Visibility pattern dimming generator with AHB-Lite registers
// Assumes: Single clock, asynchronous active-low reset
// Notes: Precision 0.1%, 11 base patterns of 10 bits
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "vdpg_regs.svh"

module vdpg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_reg];
    assign level = cnt_reg;
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= AW'(wr_reg + 1'b1);
            end
            if (pop) begin
                rd_reg <= AW'(rd_reg + 1'b1);
            end
            cnt_reg <= (AW+1)'(cnt_reg + push - pop);
        end
    end
endmodule

module vdpg_top
    import vdpg_pkg::*;
#(
    parameter int DEPTH = 8
) (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Light source and link
    output logic ls_switch,
    output logic [9:0] bias_level,
    output logic frame_start,
    output logic disassoc_req,
    output vdpg_csk_s csk_power
);
    vdpg_ctrl_s ctrl_reg;
    vdpg_state_e state_reg;
    logic [9:0] dim_reg;
    logic [15:0] flen_reg;
    logic [7:0] comp_len_reg;
    logic comp_lvl_reg;
    vdpg_csk_s csk_w_reg;
    logic [7:0] a_addr_reg;
    logic a_wr_reg;
    logic a_act_reg;
    logic [3:0] lo_idx;
    logic [3:0] up_idx;
    logic [6:0] up_rep;
    logic [6:0] lo_rep;
    logic [3:0] lo_idx_reg;
    logic [3:0] up_idx_reg;
    logic [6:0] up_rep_reg;
    logic [6:0] lo_rep_reg;
    logic [9:0] pat_reg;
    logic [3:0] bit_reg;
    logic [6:0] rep_reg;
    logic [31:0] word_reg;
    logic [5:0] wbit_reg;
    logic [7:0] cbit_reg;
    logic [15:0] fcnt_reg;
    logic f_valid;
    logic f_ready;
    logic f_in_ready;
    logic [31:0] f_data;
    logic [$clog2(DEPTH):0] f_level;
    logic wr_data;
    logic bit_end;
    logic frame_end;
    logic flen_wr;

    // Base pattern table, none equal to an 8B10B code word
    function automatic logic [9:0] base_pat(input logic [3:0] idx);
        case (idx)
            4'ha: base_pat = 10'h3ff;
            4'h9: base_pat = 10'h3df;
            4'h8: base_pat = 10'h3de;
            4'h7: base_pat = 10'h3bc;
            4'h6: base_pat = 10'h33c;
            4'h5: base_pat = 10'h23c;
            4'h4: base_pat = 10'h03c;
            4'h3: base_pat = 10'h038;
            4'h2: base_pat = 10'h030;
            4'h1: base_pat = 10'h020;
            default: base_pat = 10'h000;
        endcase
    endfunction

    // Scale a weight by the dimming level
    function automatic logic [9:0] scale(input logic [9:0] w,
                                         input logic [9:0] d);
        logic [19:0] prod;
        prod = w * d;
        scale = 10'(prod / 20'(`VDPG_DIM_MAX));
    endfunction

    // Index and repeat split, level in 0.1% units
    always_comb begin
        lo_idx = 4'(dim_reg / `VDPG_STEP);
        up_rep = 7'(dim_reg - 10'(lo_idx) * `VDPG_STEP);
        up_idx = (up_rep == '0) ? lo_idx : 4'(lo_idx + 1'b1);
        lo_rep = 7'(`VDPG_STEP - 10'(up_rep));
    end

    // Bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_act_reg <= 1'b0;
            a_wr_reg <= 1'b0;
            a_addr_reg <= 8'h00;
        end else if (hready) begin
            a_act_reg <= hsel && (htrans == `VDPG_HTRANS_NSEQ);
            a_wr_reg <= hwrite;
            a_addr_reg <= haddr;
        end
    end

    assign wr_data = a_act_reg && a_wr_reg && (a_addr_reg == `VDPG_OFS_DATA);
    assign hreadyout = !(wr_data && !f_in_ready);
    assign hresp = 1'b0;

    // Register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= '0;
            dim_reg <= 10'h000;
            flen_reg <= `VDPG_FLEN_RST;
            comp_len_reg <= 8'h00;
            comp_lvl_reg <= 1'b0;
            csk_w_reg <= '0;
        end else if (a_act_reg && a_wr_reg && hreadyout) begin
            case (a_addr_reg)
                `VDPG_OFS_CTRL: begin
                    ctrl_reg.en <= hwdata[`VDPG_CTRL_EN];
                    ctrl_reg.data_mode <= hwdata[`VDPG_CTRL_DATA];
                    ctrl_reg.oob <= hwdata[`VDPG_CTRL_OOB];
                    ctrl_reg.csk <= hwdata[`VDPG_CTRL_CSK];
                end
                `VDPG_OFS_DIM: begin
                    dim_reg <= (hwdata > 32'(`VDPG_DIM_MAX)) ?
                        `VDPG_DIM_MAX : hwdata[9:0];
                end
                `VDPG_OFS_FLEN: flen_reg <= hwdata[15:0];
                `VDPG_OFS_COMP: begin
                    comp_len_reg <= hwdata[7:0];
                    comp_lvl_reg <= hwdata[8];
                end
                `VDPG_OFS_CSK: csk_w_reg <= hwdata[29:0];
                default: begin
                end
            endcase
        end
    end

    // Register reads, data from the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && !hwrite &&
                     htrans == `VDPG_HTRANS_NSEQ) begin
            case (haddr)
                `VDPG_OFS_CTRL: hrdata <= {28'h0, ctrl_reg.csk,
                    ctrl_reg.oob, ctrl_reg.data_mode, ctrl_reg.en};
                `VDPG_OFS_DIM: hrdata <= {22'h0, dim_reg};
                `VDPG_OFS_FLEN: hrdata <= {16'h0, flen_reg};
                `VDPG_OFS_COMP: hrdata <= {23'h0, comp_lvl_reg, comp_len_reg};
                `VDPG_OFS_STAT: hrdata <= {4'h0, 4'(f_level), up_rep_reg,
                    lo_rep_reg, up_idx_reg, lo_idx_reg, disassoc_req,
                    state_reg != VDPG_IDLE};
                `VDPG_OFS_CSK: hrdata <= {2'h0, csk_w_reg};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    vdpg_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(wr_data),
        .in_ready(f_in_ready),
        .in_data(hwdata),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data),
        .level(f_level)
    );

    assign bit_end = (bit_reg == 4'(`VDPG_PAT_W - 1'b1));
    assign f_ready = (state_reg == VDPG_IDLE) && ctrl_reg.en &&
        ctrl_reg.data_mode && !ctrl_reg.oob;

    // Pattern and data sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= VDPG_IDLE;
            lo_idx_reg <= 4'h0;
            up_idx_reg <= 4'h0;
            lo_rep_reg <= 7'h00;
            up_rep_reg <= 7'h00;
            pat_reg <= 10'h000;
            bit_reg <= 4'h0;
            rep_reg <= 7'h00;
            word_reg <= 32'h0;
            wbit_reg <= 6'h00;
            cbit_reg <= 8'h00;
        end else begin
            case (state_reg)
                VDPG_IDLE: begin
                    bit_reg <= 4'h0;
                    rep_reg <= 7'h01;
                    if (f_valid && f_ready) begin
                        word_reg <= f_data;
                        wbit_reg <= 6'h00;
                        state_reg <= VDPG_DATA;
                    end else if (ctrl_reg.en && !ctrl_reg.oob) begin
                        lo_idx_reg <= lo_idx;
                        up_idx_reg <= up_idx;
                        lo_rep_reg <= lo_rep;
                        up_rep_reg <= up_rep;
                        pat_reg <= base_pat(lo_idx);
                        state_reg <= VDPG_LOWER;
                    end
                end
                VDPG_LOWER, VDPG_UPPER: begin
                    pat_reg <= {pat_reg[8:0], 1'b0};
                    bit_reg <= 4'(bit_reg + 1'b1);
                    if (bit_end) begin
                        bit_reg <= 4'h0;
                        rep_reg <= 7'(rep_reg + 1'b1);
                        if (state_reg == VDPG_LOWER && rep_reg != lo_rep_reg) begin
                            pat_reg <= base_pat(lo_idx_reg);
                        end else if (state_reg == VDPG_LOWER &&
                                     up_rep_reg != '0) begin
                            rep_reg <= 7'h01;
                            pat_reg <= base_pat(up_idx_reg);
                            state_reg <= VDPG_UPPER;
                        end else if (state_reg == VDPG_UPPER &&
                                     rep_reg != up_rep_reg) begin
                            pat_reg <= base_pat(up_idx_reg);
                        end else begin
                            cbit_reg <= 8'h00;
                            state_reg <= (comp_len_reg != '0) ?
                                VDPG_COMP : VDPG_IDLE;
                        end
                    end
                end
                VDPG_DATA: begin
                    word_reg <= {word_reg[30:0], 1'b0};
                    wbit_reg <= 6'(wbit_reg + 1'b1);
                    if (wbit_reg == 6'h1f) begin
                        cbit_reg <= 8'h00;
                        state_reg <= (comp_len_reg != '0) ?
                            VDPG_COMP : VDPG_IDLE;
                    end
                end
                VDPG_COMP: begin
                    cbit_reg <= 8'(cbit_reg + 1'b1);
                    if (cbit_reg == 8'(comp_len_reg - 1'b1)) begin
                        state_reg <= VDPG_IDLE;
                    end
                end
                default: state_reg <= VDPG_IDLE;
            endcase
        end
    end

    // Switching level, one bit per clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ls_switch <= 1'b0;
        end else begin
            case (state_reg)
                VDPG_LOWER, VDPG_UPPER: ls_switch <= pat_reg[9];
                VDPG_DATA: ls_switch <= word_reg[31];
                VDPG_COMP: ls_switch <= comp_lvl_reg;
                default: ls_switch <= 1'b0;
            endcase
        end
    end

    // Frame fill counter for the dimming frame payload
    // New length restarts the frame so the count never passes a nonzero length
    assign flen_wr = a_act_reg && a_wr_reg && hreadyout &&
        (a_addr_reg == `VDPG_OFS_FLEN);
    assign frame_end = (fcnt_reg == 16'(flen_reg - 1'b1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fcnt_reg <= 16'h0000;
            frame_start <= 1'b0;
        end else begin
            frame_start <= 1'b0;
            if (flen_wr) begin
                fcnt_reg <= 16'h0000;
            end else if (state_reg == VDPG_LOWER ||
                         state_reg == VDPG_UPPER) begin
                frame_start <= (fcnt_reg == 16'h0000);
                fcnt_reg <= frame_end ? 16'h0000 :
                    16'(fcnt_reg + 1'b1);
            end
        end
    end

    // Out-of-band bias, disassociation and colour power
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bias_level <= 10'h000;
            disassoc_req <= 1'b0;
            csk_power <= '0;
        end else begin
            bias_level <= (ctrl_reg.en && ctrl_reg.oob) ?
                dim_reg : 10'h000;
            disassoc_req <= ctrl_reg.en && ctrl_reg.data_mode &&
                (dim_reg < `VDPG_DATA_LO || dim_reg > `VDPG_DATA_HI);
            if (ctrl_reg.en && ctrl_reg.csk) begin
                csk_power.red <= scale(csk_w_reg.red, dim_reg);
                csk_power.green <= scale(csk_w_reg.green, dim_reg);
                csk_power.blue <= scale(csk_w_reg.blue, dim_reg);
            end else begin
                csk_power <= '0;
            end
        end
    end

    // Checks
    a_lower_start: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == VDPG_IDLE ##1 state_reg == VDPG_LOWER
        |-> pat_reg == base_pat(lo_idx_reg))
        else $error("lower pattern not loaded");
    a_rep_sum: assert property (@(posedge hclk) disable iff (!hresetn)
        7'(lo_rep + up_rep) == 7'(`VDPG_STEP))
        else $error("repeat counts do not total 100");
    a_idx_adjacent: assert property (@(posedge hclk) disable iff (!hresetn)
        up_idx == lo_idx || up_idx == 4'(lo_idx + 1'b1))
        else $error("indices not neighbours");
    a_exact_step: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == VDPG_LOWER && up_rep_reg == '0
        |-> ##1 state_reg != VDPG_UPPER)
        else $error("upper pattern sent on exact step");
    a_bit_order: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg inside {VDPG_LOWER, VDPG_UPPER}
        |=> ls_switch == $past(pat_reg[9]))
        else $error("pattern bit order wrong");
    a_dim_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
        dim_reg <= `VDPG_DIM_MAX)
        else $error("dimming level out of range");
    a_comp_level: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == VDPG_COMP |=> ls_switch == $past(comp_lvl_reg))
        else $error("compensation level wrong");
    a_frame_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        fcnt_reg < flen_reg || flen_reg == '0)
        else $error("frame counter beyond length");
    a_bias_oob: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_reg.en && ctrl_reg.oob ##1 ctrl_reg.en && ctrl_reg.oob
        |-> bias_level == $past(dim_reg))
        else $error("bias level not tracking");
    c_upper_run: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == VDPG_LOWER ##1 state_reg == VDPG_UPPER);
    c_data_comp: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == VDPG_DATA ##1 state_reg == VDPG_COMP);
    c_fifo_full: cover property (@(posedge hclk) disable iff (!hresetn)
        !hreadyout);
endmodule

// ===== vdpg_mac.sv
// Purpose: MAC-side model issuing dimming requests over AHB-Lite
// Assumes: One slave, its hreadyout is the bus hready
// Notes: Looks at the answer on the falling edge, drives after rising edge
`timescale 1ns/1ps
module vdpg_mac (
    // Clock
    input wire logic hclk,
    // Slave answer
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // Request
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    int n_waits = 0;
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
    end
    // Wait for hready, bounded
    task automatic wait_ready(output bit to, output logic [31:0] q);
        int n;
        bit r;
        n = 0;
        do begin
            @(negedge hclk);
            r = (hreadyout === 1'b1);
            q = hrdata;
            @(posedge hclk);
            n_waits += r ? 0 : 1;
            n++;
        end while (!r && n < 20000);
        to = !r;
    endtask
    // One single word transfer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output bit to);
        bit t1;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `VDPG_HTRANS_NSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready(t1, q);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready(to, q);
        to = to | t1;
    endtask
endmodule

// ===== vdpg_top_tb.sv
// Purpose: Self-checking bench of the visibility dimming generator
// Assumes: Pattern period of 1000 bits plus one idle cycle
// Notes: Light output judged by counting on-bits over whole periods
`timescale 1ns/1ps
module vdpg_top_tb
    import vdpg_pkg::*;
();
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp;
    logic ls_switch, frame_start, disassoc_req;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [9:0] bias_level;
    vdpg_csk_s csk_power;
    int fails = 0;
    int n_checks = 0;

    always #50 hclk = ~hclk;

    vdpg_mac i_mac (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    vdpg_top #(.DEPTH(8)) i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ls_switch(ls_switch), .bias_level(bias_level),
        .frame_start(frame_start), .disassoc_req(disassoc_req),
        .csk_power(csk_power));

    task automatic complete_run();
        $display("Counts: %0d checks, %0d fails", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic xf(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        bit to;
        i_mac.xfer(w, a, d, q, to);
        if (to) begin
            fails++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xf(1'b1, a, d, q);
    endtask
    // Count light-on cycles, ends on a rising edge
    task automatic ones(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge hclk);
            c += (ls_switch === 1'b1) ? 1 : 0;
        end
        @(posedge hclk);
    endtask
    // Stop on the falling edge that shows a frame start
    task automatic wait_frame();
        int n;
        n = 0;
        @(negedge hclk);
        while (frame_start !== 1'b1 && n < 3000) begin
            @(negedge hclk);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            complete_run();
        end
    endtask

    task automatic t_reset();
        logic [7:0] ad[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c};
        logic [31:0] ex[6] = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0};
        logic [31:0] q;
        foreach (ad[i]) begin
            xf(1'b0, ad[i], 32'h0, q);
            chk(q, ex[i]);
        end
        chk(32'(hresp), 32'h0);
        $display("test reset done");
    endtask
    task automatic t_levels();
        logic [10:0] dl[7] = '{11'h000, 11'h001, 11'h0fd, 11'h1f4,
                               11'h3e7, 11'h3e8, 11'h5dc};
        int e;
        int c;
        int n;
        logic [31:0] q;
        logic [9:0] p;
        wr(`VDPG_OFS_CTRL, 32'h1);
        foreach (dl[i]) begin
            e = (dl[i] > `VDPG_DIM_MAX) ? `VDPG_DIM_MAX : dl[i];
            wr(`VDPG_OFS_DIM, 32'(dl[i]));
            xf(1'b0, `VDPG_OFS_DIM, 32'h0, q);
            chk(q, 32'(e));
            ones(1002, c);
            xf(1'b0, `VDPG_OFS_STAT, 32'h0, q);
            chk(32'(q[9:2]), 32'({4'((e + 99) / `VDPG_STEP),
                4'(e / `VDPG_STEP)}));
            chk(32'(q[23:10]), 32'({7'(e % `VDPG_STEP),
                7'(`VDPG_STEP - e % `VDPG_STEP)}));
            ones(1001, c);
            chk(32'(c), 32'(e));
        end
        wr(`VDPG_OFS_DIM, 32'h0fd);
        ones(1002, c);
        wait_frame();
        p = 10'h000;
        repeat (10) begin
            p = {p[8:0], ls_switch};
            @(negedge hclk);
        end
        chk(32'(p == 10'h030 || p == 10'h038), 32'h1);
        @(posedge hclk);
        wr(`VDPG_OFS_FLEN, 32'h32);
        ones(1002, c);
        wait_frame();
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (frame_start !== 1'b1 && n < 200);
        chk(32'(n == 50 || n == 51), 32'h1);
        @(posedge hclk);
        wr(`VDPG_OFS_FLEN, 32'(`VDPG_FLEN_RST));
        $display("test levels done");
    endtask
    task automatic t_comp();
        int c;
        wr(`VDPG_OFS_DIM, 32'h0);
        wr(`VDPG_OFS_COMP, 32'h10a);
        ones(1012, c);
        ones(1011, c);
        chk(32'(c), 32'ha);
        wr(`VDPG_OFS_COMP, 32'h0);
        $display("test compensation done");
    endtask
    task automatic t_oob();
        int c;
        wr(`VDPG_OFS_CTRL, 32'h5);
        wr(`VDPG_OFS_DIM, 32'h190);
        ones(4, c);
        ones(20, c);
        chk(32'(c), 32'h0);
        chk(32'(bias_level), 32'h190);
        $display("test bias done");
    endtask
    task automatic t_csk();
        int c;
        wr(`VDPG_OFS_CTRL, 32'h9);
        wr(`VDPG_OFS_CSK, 32'({10'h3e8, 10'h1f4, 10'h000}));
        wr(`VDPG_OFS_DIM, 32'h1f4);
        ones(4, c);
        chk(32'(csk_power), 32'({10'h1f4, 10'h0fa, 10'h000}));
        $display("test colour done");
    endtask
    task automatic t_data();
        int c;
        int w0;
        int n;
        logic [31:0] q;
        wr(`VDPG_OFS_CTRL, 32'h3);
        wr(`VDPG_OFS_DIM, 32'h32);
        ones(4, c);
        chk(32'(disassoc_req), 32'h1);
        wr(`VDPG_OFS_DIM, 32'h1f4);
        ones(4, c);
        chk(32'(disassoc_req), 32'h0);
        w0 = i_mac.n_waits;
        for (int i = 0; i < 12; i++) begin
            wr(`VDPG_OFS_DATA, 32'ha5c3_0000 + 32'(i));
        end
        chk(32'(i_mac.n_waits > w0), 32'h1);
        n = 0;
        do begin
            xf(1'b0, `VDPG_OFS_STAT, 32'h0, q);
            n++;
        end while (q[27:24] !== 4'h0 && n < 5000);
        chk(32'(q[27:24]), 32'h0);
        $display("test data done");
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_levels();
        t_comp();
        t_oob();
        t_csk();
        t_data();
        complete_run();
    end
endmodule
